// >>> core/ssrm_defines.vh
// Constants for the safety stop response manager
`ifndef SSRM_DEFINES_VH
`define SSRM_DEFINES_VH

// Stop codes
`define SSRM_STOP_NONE   3'h0
`define SSRM_STOP_PULSE  3'h1
`define SSRM_STOP_BRAKE  3'h2
`define SSRM_STOP_HOLDB  3'h3
`define SSRM_STOP_HOLDP  3'h4
`define SSRM_STOP_HOLDR  3'h5
`define SSRM_STOP_MISM   3'h6
`define SSRM_STOP_TEST   3'h7

// Stop categories
`define SSRM_CAT_0       2'h0
`define SSRM_CAT_1       2'h1
`define SSRM_CAT_2       2'h2
`define SSRM_CAT_NONE    2'h3

// Request vector bit positions
`define SSRM_REQ_PULSE   0
`define SSRM_REQ_BRAKE   1
`define SSRM_REQ_TEST    2
`define SSRM_REQ_HOLDB   3
`define SSRM_REQ_HOLDP   4
`define SSRM_REQ_HOLDR   5
`define SSRM_REQ_MISM    6

// Defaults
`define SSRM_BRAKE_TIME_DEF 16'h0100
`define SSRM_HOLD_TIME_DEF  16'h0100

`endif

// >>> core/ssrm_stop_manager.v
// Stop response manager for one two-channel safety-monitored axis
`timescale 1ns/1ps
`include "ssrm_defines.vh"

module ssrm_stop_manager #(
    parameter TW = 16
) (
    input  wire          clk,
    input  wire          reset_n,
    input  wire          monitor_active,
    input  wire          viol_safe_operating_stop,
    input  wire          viol_safe_braking_ramp,
    input  wire          viol_safe_speed_limit,
    input  wire [2:0]    cfg_safe_speed_limit_stop,
    input  wire          viol_safe_end_position,
    input  wire [2:0]    cfg_safe_end_position_stop,
    input  wire          viol_safe_cam,
    input  wire          cross_mismatch,
    input  wire          test_stop_sel,
    input  wire [2:0]    peer_stop,
    input  wire          below_standstill_speed_tolerance,
    input  wire [TW-1:0] pulse_disable_delay,
    input  wire [TW-1:0] hold_stop_delay,
    output reg  [2:0]    stop_active,
    output reg  [1:0]    stop_category,
    output reg  [2:0]    mirror_stop,
    output reg           pulse_cancel,
    output reg           gating_suppress,
    output reg           pulse_enable,
    output reg           group_stop,
    output reg           safe_standstill,
    output reg           safe_operating_stop,
    output reg           zero_setpoint,
    output reg           current_limit_brake,
    output reg           hard_stop_active,
    output reg           alarm_pulse_stop,
    output reg           alarm_brake_stop
);

    // Rank of a stop, lower is stronger; 7 means none
    function [2:0] rank;
        input [2:0] s;
        begin
            case (s)
                `SSRM_STOP_PULSE: rank = 3'h0;
                `SSRM_STOP_BRAKE: rank = 3'h1;
                `SSRM_STOP_TEST:  rank = 3'h2;
                `SSRM_STOP_HOLDB: rank = 3'h3;
                `SSRM_STOP_HOLDP: rank = 3'h4;
                `SSRM_STOP_HOLDR: rank = 3'h5;
                `SSRM_STOP_MISM:  rank = 3'h6;
                default:          rank = 3'h7;
            endcase
        end
    endfunction

    // Category of a stop
    function [1:0] categ;
        input [2:0] s;
        begin
            case (s)
                `SSRM_STOP_PULSE: categ = `SSRM_CAT_0;
                `SSRM_STOP_BRAKE: categ = `SSRM_CAT_1;
                `SSRM_STOP_MISM:  categ = `SSRM_CAT_1;
                `SSRM_STOP_HOLDB: categ = `SSRM_CAT_2;
                `SSRM_STOP_HOLDP: categ = `SSRM_CAT_2;
                `SSRM_STOP_HOLDR: categ = `SSRM_CAT_2;
                default:          categ = `SSRM_CAT_NONE;
            endcase
        end
    endfunction

    // Stop code to request vector bit
    function [6:0] to_req;
        input [2:0] s;
        begin
            to_req = 7'h00;
            case (s)
                `SSRM_STOP_PULSE: to_req[`SSRM_REQ_PULSE] = 1'b1;
                `SSRM_STOP_BRAKE: to_req[`SSRM_REQ_BRAKE] = 1'b1;
                `SSRM_STOP_TEST:  to_req[`SSRM_REQ_TEST]  = 1'b1;
                `SSRM_STOP_HOLDB: to_req[`SSRM_REQ_HOLDB] = 1'b1;
                `SSRM_STOP_HOLDP: to_req[`SSRM_REQ_HOLDP] = 1'b1;
                `SSRM_STOP_HOLDR: to_req[`SSRM_REQ_HOLDR] = 1'b1;
                `SSRM_STOP_MISM:  to_req[`SSRM_REQ_MISM]  = 1'b1;
                default:          to_req = 7'h00;
            endcase
        end
    endfunction

    // Timer count one down
    function [TW-1:0] dec;
        input [TW-1:0] t;
        begin
            dec = t - {{(TW-1){1'b0}}, 1'b1};
        end
    endfunction

    // Timer run out
    function is_zero;
        input [TW-1:0] t;
        begin
            is_zero = (t == {TW{1'b0}});
        end
    endfunction

    // Stops that brake along the current limit
    function brakes;
        input [2:0] s;
        begin
            brakes = (s == `SSRM_STOP_BRAKE) || (s == `SSRM_STOP_HOLDB);
        end
    endfunction

    reg [2:0]    stop_q;
    reg [2:0]    stop_d;
    reg [TW-1:0] timer_q;
    reg [TW-1:0] timer_d;
    reg          hold_done_q;
    reg          hold_done_d;
    reg [6:0]    req;
    reg [2:0]    cand;
    reg [2:0]    ss_sel;
    reg [2:0]    se_sel;

    // Map monitoring functions to request vector
    always @* begin
        req = 7'h00;
        if (viol_safe_operating_stop)
            req[`SSRM_REQ_BRAKE] = 1'b1;
        if (viol_safe_braking_ramp)
            req[`SSRM_REQ_PULSE] = 1'b1;
        // speed limit any of five stops
        ss_sel = cfg_safe_speed_limit_stop;
        if (viol_safe_speed_limit && ss_sel >= `SSRM_STOP_PULSE
                && ss_sel <= `SSRM_STOP_HOLDR)
            req = req | to_req(ss_sel);
        se_sel = cfg_safe_end_position_stop;
        if (viol_safe_end_position && se_sel >= `SSRM_STOP_HOLDB
                && se_sel <= `SSRM_STOP_HOLDR)
            req = req | to_req(se_sel);
        if (viol_safe_cam)
            req = req;
        if (test_stop_sel)
            req[`SSRM_REQ_TEST] = 1'b1;
        if (peer_stop != `SSRM_STOP_TEST)
            req = req | to_req(peer_stop);
        if (!monitor_active)
            req = 7'h00;
        if (cross_mismatch)
            req[`SSRM_REQ_MISM] = 1'b1;
        if (req[`SSRM_REQ_MISM] && monitor_active)
            req[`SSRM_REQ_BRAKE] = 1'b1;
        if (req[`SSRM_REQ_PULSE])
            cand = `SSRM_STOP_PULSE;
        else if (req[`SSRM_REQ_BRAKE])
            cand = `SSRM_STOP_BRAKE;
        else if (req[`SSRM_REQ_TEST])
            cand = `SSRM_STOP_TEST;
        else if (req[`SSRM_REQ_HOLDB])
            cand = `SSRM_STOP_HOLDB;
        else if (req[`SSRM_REQ_HOLDP])
            cand = `SSRM_STOP_HOLDP;
        else if (req[`SSRM_REQ_HOLDR])
            cand = `SSRM_STOP_HOLDR;
        else if (req[`SSRM_REQ_MISM])
            cand = `SSRM_STOP_MISM;
        else
            cand = `SSRM_STOP_NONE;
    end

    // Next stop state and timer
    always @* begin
        stop_d      = stop_q;
        timer_d     = timer_q;
        hold_done_d = hold_done_q;
        // keep running stop, accept only stronger
        if (rank(cand) < rank(stop_q)) begin
            stop_d      = cand;
            hold_done_d = 1'b0;
            if (cand == `SSRM_STOP_BRAKE)
                timer_d = pulse_disable_delay;
            else
                timer_d = hold_stop_delay;
        end else begin
            case (stop_q)
                `SSRM_STOP_BRAKE: begin
                    if (is_zero(timer_q) || below_standstill_speed_tolerance)
                        stop_d = `SSRM_STOP_PULSE;
                    else
                        timer_d = dec(timer_q);
                end
                `SSRM_STOP_HOLDB, `SSRM_STOP_HOLDP,
                `SSRM_STOP_HOLDR: begin
                    if (is_zero(timer_q))
                        hold_done_d = 1'b1;
                    else
                        timer_d = dec(timer_q);
                end
                default: begin
                    stop_d = stop_q;
                end
            endcase
        end
    end

    // State registers; only reset clears hard stops
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stop_q      <= `SSRM_STOP_NONE;
            timer_q     <= {TW{1'b0}};
            hold_done_q <= 1'b0;
        end else begin
            stop_q      <= stop_d;
            timer_q     <= timer_d;
            hold_done_q <= hold_done_d;
        end
    end

    // Registered outputs
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stop_active         <= `SSRM_STOP_NONE;
            stop_category       <= `SSRM_CAT_NONE;
            mirror_stop         <= `SSRM_STOP_NONE;
            pulse_cancel        <= 1'b0;
            gating_suppress     <= 1'b0;
            pulse_enable        <= 1'b0;
            group_stop          <= 1'b0;
            safe_standstill     <= 1'b0;
            safe_operating_stop <= 1'b0;
            zero_setpoint       <= 1'b0;
            current_limit_brake <= 1'b0;
            hard_stop_active    <= 1'b0;
            alarm_pulse_stop    <= 1'b0;
            alarm_brake_stop    <= 1'b0;
        end else begin
            stop_active   <= stop_d;
            stop_category <= categ(stop_d);
            // signal to peer, not the test stop
            mirror_stop   <= (stop_d == `SSRM_STOP_TEST) ?
                             `SSRM_STOP_NONE : stop_d;
            pulse_cancel    <= stop_d == `SSRM_STOP_PULSE;
            gating_suppress <= stop_d == `SSRM_STOP_PULSE;
            pulse_enable    <= stop_d != `SSRM_STOP_PULSE;
            group_stop      <= stop_d == `SSRM_STOP_PULSE;
            safe_standstill <= stop_d == `SSRM_STOP_PULSE;
            safe_operating_stop <= hold_done_d;
            zero_setpoint       <= brakes(stop_d);
            current_limit_brake <= brakes(stop_d);
            hard_stop_active <= stop_d == `SSRM_STOP_PULSE
                                || stop_d == `SSRM_STOP_BRAKE;
            alarm_pulse_stop <= stop_d == `SSRM_STOP_PULSE
                                && stop_q != `SSRM_STOP_PULSE;
            alarm_brake_stop <= stop_d == `SSRM_STOP_BRAKE
                                && stop_q != `SSRM_STOP_BRAKE;
        end
    end

endmodule

// >>> tb/ssrm_peer_model.sv
// Peer channel model that echoes or injects stops
`timescale 1ns/1ps
module ssrm_peer_model (
    input  wire       clk,
    input  wire       reset_n,
    input  wire [2:0] mirror_stop,
    input  wire [2:0] inject,
    output reg  [2:0] peer_stop
);
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            peer_stop <= 3'h0;
        end else begin
            peer_stop <= (inject != 3'h0) ? inject : mirror_stop;
        end
    end
endmodule

// >>> tb/ssrm_checker_props.sv
// Property checker for the stop response manager
`timescale 1ns/1ps
`include "ssrm_defines.vh"
module ssrm_checker (
    input wire       clk,
    input wire       reset_n,
    input wire       monitor_active,
    input wire       cross_mismatch,
    input wire [2:0] peer_stop,
    input wire       below_standstill_speed_tolerance,
    input wire [2:0] stop_active,
    input wire [2:0] mirror_stop,
    input wire       pulse_cancel,
    input wire       gating_suppress,
    input wire       pulse_enable,
    input wire       group_stop,
    input wire       safe_standstill,
    input wire       safe_operating_stop,
    input wire       zero_setpoint,
    input wire       current_limit_brake,
    input wire       hard_stop_active,
    input wire       alarm_pulse_stop,
    input wire       alarm_brake_stop
);
    wire p = stop_active == `SSRM_STOP_PULSE;
    wire b = stop_active == `SSRM_STOP_BRAKE;
    wire i = stop_active == `SSRM_STOP_NONE;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    hard_flag_a: assert property (hard_stop_active == (p || b))
        else $error("hard flag wrong");
    pulse_out_a:
        assert property (p |-> pulse_cancel && gating_suppress
            && !pulse_enable && safe_standstill) else $error("pulse outs");
    pulse_keep_a: assert property (p |=> p) else $error("pulse left");
    brake_keep_a: assert property (b |=> p || b)
        else $error("braked left");
    stand_go_a:
        assert property (b && below_standstill_speed_tolerance |->
            ##[1:3] p) else $error("no pulse at standstill");
    mirror_out_a:
        assert property (mirror_stop == ((stop_active == `SSRM_STOP_TEST)
            ? `SSRM_STOP_NONE : stop_active)) else $error("mirror wrong");
    alarm_pulse_a: assert property (p && !$past(p) |-> alarm_pulse_stop)
        else $error("no pulse alarm");
    alarm_brake_a: assert property (b && !$past(b) |-> alarm_brake_stop)
        else $error("no braked alarm");
    idle_keep_a:
        assert property (i && !monitor_active && !cross_mismatch
            && peer_stop == `SSRM_STOP_NONE |=> i) else $error("stop idle");
    mism_go_a:
        assert property (i && monitor_active && cross_mismatch |=> p || b)
            else $error("no escalation");
    group_out_a: assert property (group_stop == p)
        else $error("group stop wrong");
    brake_outs_a:
        assert property (zero_setpoint == (b
            || stop_active == `SSRM_STOP_HOLDB)
            && current_limit_brake == zero_setpoint)
            else $error("braking outs wrong");
    hold_done_a:
        assert property (safe_operating_stop |->
            stop_active >= `SSRM_STOP_HOLDB
            && stop_active <= `SSRM_STOP_HOLDR) else $error("early op stop");
    cover property (p);
    cover property (b);
    cover property (stop_active == `SSRM_STOP_MISM);
endmodule
bind ssrm_stop_manager ssrm_checker u_chk (.*);

// >>> tb/tb_top.sv
// Testbench for the stop response manager
`timescale 1ns/1ps
`include "ssrm_defines.vh"
module tb_top;
    reg         clk = 1'b0;
    reg         reset_n = 1'b0;
    reg         mon, vos, vbr, vsl, vep, cam, mis, tst, slow;
    reg  [2:0]  cfg_sl, cfg_ep, inj, c;
    reg  [15:0] pdd = 16'h0100;
    reg  [15:0] hsd = 16'h0004;
    wire [2:0]  sa, mir, peer;
    wire [1:0]  cat;
    wire        pe, hsa, sos;
    integer     n_fail = 0;
    integer     checked = 0;
    integer     k;

    always #20 clk = ~clk;

    ssrm_peer_model u_peer (.clk(clk), .reset_n(reset_n),
        .mirror_stop(mir), .inject(inj), .peer_stop(peer));
    ssrm_stop_manager dut (.clk(clk), .reset_n(reset_n),
        .monitor_active(mon), .viol_safe_operating_stop(vos),
        .viol_safe_braking_ramp(vbr), .viol_safe_speed_limit(vsl),
        .cfg_safe_speed_limit_stop(cfg_sl), .viol_safe_end_position(vep),
        .cfg_safe_end_position_stop(cfg_ep), .viol_safe_cam(cam),
        .cross_mismatch(mis), .test_stop_sel(tst), .peer_stop(peer),
        .below_standstill_speed_tolerance(slow),
        .pulse_disable_delay(pdd), .hold_stop_delay(hsd),
        .stop_active(sa), .stop_category(cat), .mirror_stop(mir),
        .pulse_cancel(), .gating_suppress(), .pulse_enable(pe),
        .group_stop(), .safe_standstill(), .safe_operating_stop(sos),
        .zero_setpoint(), .current_limit_brake(),
        .hard_stop_active(hsa), .alarm_pulse_stop(), .alarm_brake_stop());

    function [1:0] cx(input [2:0] s);
        cx = (s == `SSRM_STOP_PULSE) ? `SSRM_CAT_0 :
            (s == `SSRM_STOP_BRAKE || s == `SSRM_STOP_MISM) ? `SSRM_CAT_1 :
            (s == `SSRM_STOP_NONE || s == `SSRM_STOP_TEST) ? `SSRM_CAT_NONE
            : `SSRM_CAT_2;
    endfunction

    task wt(input integer n);
        repeat (n) @(posedge clk);
    endtask

    task go(input integer n, input [2:0] s);
        begin
            wt(n);
            #1;
            checked = checked + 1;
            if (sa !== s || cat !== cx(s) || hsa !== (s == `SSRM_STOP_PULSE
                || s == `SSRM_STOP_BRAKE) || pe !== (reset_n
                && s != `SSRM_STOP_PULSE) || mir !== ((s == `SSRM_STOP_TEST)
                ? 3'h0 : s)) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0t stop %h cat %h exp %h", $time, sa, cat, s);
            end
            @(posedge clk);
        end
    endtask

    task sos_chk(input e);
        begin
            #1;
            checked = checked + 1;
            if (sos !== e) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0t operating stop %b exp %b", $time, sos, e);
            end
            @(posedge clk);
        end
    endtask

    task rst(input integer n);
        begin
            reset_n <= 1'b0;
            {mon, vos, vbr, vsl, vep, cam, mis, tst, slow} <= 9'h000;
            {cfg_sl, cfg_ep, inj} <= 9'h000;
            go(n, `SSRM_STOP_NONE);
            reset_n <= 1'b1;
        end
    endtask

    task wrap_up;
        begin
            $display("checked %0d n_fail %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask

    initial begin
        #200000;
        n_fail = n_fail + 1;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up;
    end

    initial begin
        rst(15);
        {vos, vbr} <= 2'h3;
        go(3, `SSRM_STOP_NONE);
        {vos, vbr, mon, cam} <= 4'h3;
        go(3, `SSRM_STOP_NONE);
        $display("test idle done");
        for (k = 0; k < 16; k = k + 1) begin
            rst(1);
            c = k[2:0];
            {mon, vsl, vep} <= {1'b1, ~k[3], k[3]};
            {cfg_sl, cfg_ep} <= {c, c};
            go(2, (c >= (k[3] ? 3 : 1) && c <= 5) ? c : 3'h0);
        end
        $display("test config done");
        rst(1);
        {mon, vep} <= 2'h3;
        cfg_ep <= `SSRM_STOP_HOLDB;
        go(2, `SSRM_STOP_HOLDB);
        sos_chk(1'b0);
        cfg_ep <= `SSRM_STOP_HOLDR;
        go(3, `SSRM_STOP_HOLDB);
        vep <= 1'b0;
        go(3, `SSRM_STOP_HOLDB);
        sos_chk(1'b1);
        tst <= 1'b1;
        go(2, `SSRM_STOP_TEST);
        vos <= 1'b1;
        go(2, `SSRM_STOP_BRAKE);
        slow <= 1'b1;
        go(3, `SSRM_STOP_PULSE);
        {mon, vos, tst, slow} <= 4'h0;
        go(20, `SSRM_STOP_PULSE);
        $display("test priority done");
        rst(1);
        {mon, vbr} <= 2'h3;
        go(2, `SSRM_STOP_PULSE);
        rst(1);
        pdd <= 16'h0000;
        {mon, vos} <= 2'h3;
        go(4, `SSRM_STOP_PULSE);
        pdd <= 16'h0100;
        $display("test hard stops done");
        rst(1);
        mis <= 1'b1;
        go(3, `SSRM_STOP_MISM);
        rst(1);
        {mon, mis} <= 2'h3;
        go(2, `SSRM_STOP_BRAKE);
        rst(1);
        mon <= 1'b1;
        inj <= `SSRM_STOP_HOLDP;
        go(3, `SSRM_STOP_HOLDP);
        rst(1);
        mon <= 1'b1;
        inj <= `SSRM_STOP_TEST;
        go(3, `SSRM_STOP_NONE);
        $display("test mismatch and peer done");
        wrap_up;
    end
endmodule
